// ---- logic/fabric_clk_pkg.sv ----
// package: constants and types for fabric clock and set/reset distribution
package fabric_clk_pkg;

	// ***************************************************************
	// array shape
	// ***************************************************************
	localparam int NUM_GLOBAL_CLK   = 8;
	localparam int NUM_FAST_CLK     = 4;
	localparam int CELLS_PER_SECTOR = 4;

	// ***************************************************************
	// column clock selector codes
	// ***************************************************************
	localparam int          COL_SEL_W     = 4;
	localparam logic [3:0]  SEL_FAST_A    = 4'h8;
	localparam logic [3:0]  SEL_FAST_B    = 4'h9;

	// ***************************************************************
	// values after reset and the set/reset active level
	// ***************************************************************
	localparam logic        CELL_Q_RESET  = 1'h1;
	localparam logic        SEC_CLK_IDLE  = 1'h0;
	localparam logic        SYNC_RESET    = 1'h0;
	localparam logic        SR_ACTIVE_LVL = 1'h0;

	// ***************************************************************
	// enumerations
	// ***************************************************************
	typedef enum logic [2:0] {
		CLK_TRUE = 3'h1,
		CLK_INV  = 3'h2,
		CLK_OFF  = 3'h4
	} clk_mode_type;

	typedef enum logic [2:0] {
		PH_UNCONF = 3'h1,
		PH_INIT   = 3'h2,
		PH_RUN    = 3'h4
	} phase_type;

	// ***************************************************************
	// configuration carriers
	// ***************************************************************
	typedef struct packed {
		logic         clk_from_express;
		clk_mode_type clk_mode;
		logic         sr_from_express;
		logic         sr_invert;
	} sector_cfg_type;

	typedef struct packed {
		logic falling_edge;
		logic sr_sets;
		logic init_set;
	} cell_cfg_type;

	localparam sector_cfg_type SECTOR_CFG_RESET = '{1'h0, CLK_OFF, 1'h0, 1'h0};
	localparam cell_cfg_type   CELL_CFG_RESET   = '{1'h0, 1'h1, 1'h1};

endpackage : fabric_clk_pkg

// ---- logic/sector_selector.sv ----
// module: per-sector clock and set/reset selector
`timescale 1ns/1ps
module sector_selector (
	// configuration
	input  wire fabric_clk_pkg::sector_cfg_type cfg_i,
	input  wire fabric_clk_pkg::phase_type      phase_i,
	// sources
	input  wire logic                           col_clk_i,
	input  wire logic                           express_clk_i,
	input  wire logic                           gsr_n_i,
	input  wire logic                           express_sr_i,
	// delivered
	output logic                                sec_clk_o,
	output logic                                sec_sr_n_o
);
	import fabric_clk_pkg::*;

	logic src_clk;
	logic src_sr;

	assign src_clk = cfg_i.clk_from_express ? express_clk_i : col_clk_i;
	assign src_sr  = cfg_i.sr_from_express ? express_sr_i : gsr_n_i;

	always_comb begin
		if (phase_i == PH_UNCONF) begin
			sec_clk_o = SEC_CLK_IDLE;
		end else begin
			case (cfg_i.clk_mode)
				CLK_TRUE: sec_clk_o = src_clk;
				CLK_INV:  sec_clk_o = ~src_clk;
				CLK_OFF:  sec_clk_o = SEC_CLK_IDLE;
				default:  sec_clk_o = SEC_CLK_IDLE;
			endcase
		end
	end

	// true or inverted only, never tied off
	assign sec_sr_n_o = cfg_i.sr_invert ? ~src_sr : src_sr;

endmodule : sector_selector

// ---- logic/cell_register.sv ----
// module: one fabric cell register with edge sense and set/reset
`timescale 1ns/1ps
module cell_register (
	// clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         resetn_i,
	// configuration
	input  wire fabric_clk_pkg::cell_cfg_type cfg_i,
	input  wire fabric_clk_pkg::phase_type    phase_i,
	// delivered clock and set/reset
	input  wire logic                         sec_clk_i,
	input  wire logic                         sec_sr_n_i,
	// data
	input  wire logic                         d_i,
	output logic                              q_o
);
	import fabric_clk_pkg::*;

	logic q;
	logic clk_prev;
	logic edge_seen;
	logic sr_active;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			clk_prev <= SEC_CLK_IDLE;
		end else begin
			clk_prev <= sec_clk_i;
		end
	end

	// rising edge unless falling is configured
	assign edge_seen = cfg_i.falling_edge ? (clk_prev & ~sec_clk_i)
	                                      : (~clk_prev & sec_clk_i);
	assign sr_active = (phase_i == PH_RUN) && (sec_sr_n_i == SR_ACTIVE_LVL);

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			q <= CELL_Q_RESET;
		end else begin
			case (phase_i)
				PH_UNCONF: q <= CELL_Q_RESET;
				PH_INIT:   q <= cfg_i.init_set;
				PH_RUN: begin
					if (sr_active) begin
						q <= cfg_i.sr_sets;
					end else if (edge_seen) begin
						q <= d_i;
					end
				end
				default:   q <= CELL_Q_RESET;
			endcase
		end
	end

	// set/reset overrides without waiting for a clock edge
	assign q_o = sr_active ? cfg_i.sr_sets : q;

endmodule : cell_register

// ---- logic/fabric_clock_reset_distribution.sv ----
// module: top of fabric clock and set/reset distribution
//
// Summary of operation
// - Eight global clock lines exist, each taken from its own dedicated global clock pin.
// - Four fast clock lines exist, two for the west edge column and two for the east one.
// - A selector at the top of each column picks one of the eight global lines as column clock.
// - Each four-cell sector passes its clock true, inverted, or tied to 0 to save power.
// - Each sector takes its clock from the column clock or from the plane 4 express bus.
// - The west column selector also offers the two west fast clocks, the east one the east pair.
// - Each cell register captures on the rising edge of its clock unless set to falling.
// - Before configuration completes every register clock is held at constant 0.
// - When configuration completes each register goes to its configured set or reset state.
// - One global set/reset line exists, driven from any user pin but never from a clock pin.
// - Global set/reset reaches every column and each sector picks it or the plane 5 bus.
// - Each sector passes its set/reset true or inverted, with no tie-off.
// - A per-cell bit decides whether set/reset sets or resets, active at 0 by default.
// - An active set/reset changes the register state at once, with no clock edge.
// - Before configuration every register is held set, presenting logic 1.
`timescale 1ns/1ps
module fabric_clock_reset_distribution #(
	parameter int NUM_COLS       = 4,
	parameter int SECTORS_PER_COL = 2,
	parameter int NUM_USER_IO    = 8
) (
	// clock and reset
	input  wire logic                                       clk_sys_i,
	input  wire logic                                       resetn_i,
	// clock pins
	input  wire logic [fabric_clk_pkg::NUM_GLOBAL_CLK-1:0]  global_clock_lines_i,
	input  wire logic                                       fast_clk_west_a_i,
	input  wire logic                                       fast_clk_west_b_i,
	input  wire logic                                       fast_clk_east_a_i,
	input  wire logic                                       fast_clk_east_b_i,
	// user pins and express buses
	input  wire logic [NUM_USER_IO-1:0]                     user_io_i,
	input  wire logic [NUM_COLS*SECTORS_PER_COL-1:0]        express_clk_i,
	input  wire logic [NUM_COLS*SECTORS_PER_COL-1:0]        express_sr_i,
	// configuration
	input  wire logic                                       config_done_i,
	input  wire logic [NUM_COLS*fabric_clk_pkg::COL_SEL_W-1:0] col_clk_sel_i,
	input  wire fabric_clk_pkg::sector_cfg_type [NUM_COLS*SECTORS_PER_COL-1:0] sector_cfg_i,
	input  wire fabric_clk_pkg::cell_cfg_type
		[NUM_COLS*SECTORS_PER_COL*fabric_clk_pkg::CELLS_PER_SECTOR-1:0] cell_cfg_i,
	input  wire logic [$clog2(NUM_USER_IO)-1:0]             gsr_pin_sel_i,
	// cell data
	input  wire logic
		[NUM_COLS*SECTORS_PER_COL*fabric_clk_pkg::CELLS_PER_SECTOR-1:0] cell_d_i,
	output logic
		[NUM_COLS*SECTORS_PER_COL*fabric_clk_pkg::CELLS_PER_SECTOR-1:0] cell_q_o,
	// status
	output logic                                            configured_o
);
	import fabric_clk_pkg::*;

	localparam int NUM_SEC   = NUM_COLS * SECTORS_PER_COL;
	localparam int NUM_CELLS = NUM_SEC * CELLS_PER_SECTOR;
	localparam int SEL_IO_W  = $clog2(NUM_USER_IO);
	localparam int SYNC_W    = NUM_GLOBAL_CLK + NUM_FAST_CLK + 2 * NUM_SEC + NUM_USER_IO;

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_pins;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			sync_meta <= {SYNC_W{SYNC_RESET}};
			sync_pins <= {SYNC_W{SYNC_RESET}};
		end else begin
			sync_meta <= {global_clock_lines_i,
			              fast_clk_west_a_i, fast_clk_west_b_i,
			              fast_clk_east_a_i, fast_clk_east_b_i,
			              express_clk_i, express_sr_i, user_io_i};
			sync_pins <= sync_meta;
		end
	end

	logic [NUM_GLOBAL_CLK-1:0] gclk;
	logic [NUM_FAST_CLK-1:0]   fclk;
	logic [NUM_SEC-1:0]        xclk;
	logic [NUM_SEC-1:0]        xsr;
	logic [NUM_USER_IO-1:0]    uio;

	// each global line from its own dedicated pin
	assign {gclk, fclk, xclk, xsr, uio} = sync_pins;

	// ***************************************************************
	// configuration phase
	// ***************************************************************
	phase_type phase;
	phase_type next_phase;

	always_comb begin
		case (phase)
			PH_UNCONF: next_phase = config_done_i ? PH_INIT : PH_UNCONF;
			PH_INIT:   next_phase = PH_RUN;
			PH_RUN:    next_phase = config_done_i ? PH_RUN : PH_UNCONF;
			default:   next_phase = PH_UNCONF;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			phase <= PH_UNCONF;
		end else begin
			phase <= next_phase;
		end
	end

	assign configured_o = (phase == PH_RUN);

	// ***************************************************************
	// configuration capture, frozen once configured
	// ***************************************************************
	logic [NUM_COLS*COL_SEL_W-1:0]   col_sel;
	sector_cfg_type [NUM_SEC-1:0]    sec_cfg;
	cell_cfg_type [NUM_CELLS-1:0]    cel_cfg;
	logic [SEL_IO_W-1:0]             gsr_sel;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			col_sel <= '0;
			sec_cfg <= {NUM_SEC{SECTOR_CFG_RESET}};
			cel_cfg <= {NUM_CELLS{CELL_CFG_RESET}};
			gsr_sel <= '0;
		end else if (phase == PH_UNCONF) begin
			col_sel <= col_clk_sel_i;
			sec_cfg <= sector_cfg_i;
			cel_cfg <= cell_cfg_i;
			gsr_sel <= gsr_pin_sel_i;
		end
	end

	// ***************************************************************
	// global set/reset from user pins only
	// ***************************************************************
	logic gsr_n;

	// clock pins are not among the user pins, so they cannot drive it
	assign gsr_n = uio[gsr_sel];

	// ***************************************************************
	// column clock selectors and sectors
	// ***************************************************************
	logic [NUM_COLS-1:0] col_clk;
	logic [NUM_SEC-1:0]  sec_clk;
	logic [NUM_SEC-1:0]  sec_sr_n;

	genvar c;
	genvar s;
	genvar k;
	generate
		for (c = 0; c < NUM_COLS; c++) begin : g_col
			logic [COL_SEL_W-1:0] sel;
			logic                 fast_a;
			logic                 fast_b;
			logic                 fast_ok;

			assign sel = col_sel[c*COL_SEL_W +: COL_SEL_W];

			// edge columns get their own fast pair
			if (c == 0) begin : g_west
				assign fast_a  = fclk[3];
				assign fast_b  = fclk[2];
				assign fast_ok = 1'h1;
			end else if (c == NUM_COLS - 1) begin : g_east
				assign fast_a  = fclk[1];
				assign fast_b  = fclk[0];
				assign fast_ok = 1'h1;
			end else begin : g_inner
				assign fast_a  = 1'h0;
				assign fast_b  = 1'h0;
				assign fast_ok = 1'h0;
			end

			always_comb begin
				if (sel < SEL_FAST_A) begin
					col_clk[c] = gclk[sel[2:0]];
				end else if (sel == SEL_FAST_A) begin
					col_clk[c] = fast_ok & fast_a;
				end else if (sel == SEL_FAST_B) begin
					col_clk[c] = fast_ok & fast_b;
				end else begin
					col_clk[c] = SEC_CLK_IDLE;
				end
			end

			for (s = 0; s < SECTORS_PER_COL; s++) begin : g_sec
				localparam int SI = c * SECTORS_PER_COL + s;

				// global set/reset reaches every column's sectors
				sector_selector u_sector (
					.cfg_i         (sec_cfg[SI]),
					.phase_i       (phase),
					.col_clk_i     (col_clk[c]),
					.express_clk_i (xclk[SI]),
					.gsr_n_i       (gsr_n),
					.express_sr_i  (xsr[SI]),
					.sec_clk_o     (sec_clk[SI]),
					.sec_sr_n_o    (sec_sr_n[SI])
				);

				for (k = 0; k < CELLS_PER_SECTOR; k++) begin : g_cell
					localparam int CI = SI * CELLS_PER_SECTOR + k;

					cell_register u_cell (
						.clk_sys_i  (clk_sys_i),
						.resetn_i   (resetn_i),
						.cfg_i      (cel_cfg[CI]),
						.phase_i    (phase),
						.sec_clk_i  (sec_clk[SI]),
						.sec_sr_n_i (sec_sr_n[SI]),
						.d_i        (cell_d_i[CI]),
						.q_o        (cell_q_o[CI])
					);
				end
			end
		end
	endgenerate

endmodule : fabric_clock_reset_distribution

// ---- testbench/fabric_clock_reset_distribution_props.sv ----
// checker: port properties of the fabric clock and set/reset block
`timescale 1ns/1ps
module fabric_clock_reset_distribution_props #(
	parameter int NUM_COLS		= 4,
	parameter int SECTORS_PER_COL	= 2,
	parameter int NUM_USER_IO	= 8,
	parameter int NSEC		= NUM_COLS * SECTORS_PER_COL
) (
	// clock and reset
	input wire logic			clk_sys_i,
	input wire logic			resetn_i,
	// pins
	input wire logic [7:0]			global_clock_lines_i,
	input wire logic			fast_clk_west_a_i,
	input wire logic			fast_clk_west_b_i,
	input wire logic			fast_clk_east_a_i,
	input wire logic			fast_clk_east_b_i,
	input wire logic [NUM_USER_IO-1:0]	user_io_i,
	input wire logic [NSEC-1:0]		express_clk_i,
	input wire logic [NSEC-1:0]		express_sr_i,
	input wire logic			config_done_i,
	// outputs
	input wire logic [NSEC*4-1:0]		cell_q_o,
	input wire logic			configured_o
);
	// ****************************************
	// all clock and set/reset pins together
	// ****************************************
	logic [11+NUM_USER_IO+2*NSEC:0] pins;
	assign pins = {global_clock_lines_i, fast_clk_west_a_i, fast_clk_west_b_i,
		fast_clk_east_a_i, fast_clk_east_b_i, user_io_i, express_clk_i, express_sr_i};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// ****************************************
	// properties
	// ****************************************
	reset_values_a: assert property ($rose(resetn_i) |-> &cell_q_o && !configured_o)
		else $error("outputs not at reset values");
	unconf_ones_a: assert property (!config_done_i [*3] |-> &cell_q_o)
		else $error("cells not set while unconfigured");
	unconf_idle_a: assert property (!config_done_i [*3] |-> !configured_o)
		else $error("running without configuration");
	run_needs_done_a: assert property (configured_o |-> $past(config_done_i))
		else $error("running without done");
	run_entry_a: assert property ($rose(config_done_i) |->
		!configured_o ##1 !configured_o ##1 (configured_o || !config_done_i))
		else $error("run phase entered at wrong time");
	run_hold_a: assert property (configured_o && config_done_i |=> configured_o)
		else $error("run phase left while done high");
	run_exit_a: assert property ($fell(config_done_i) |=> !configured_o)
		else $error("run phase kept after done fell");
	q_quiet_a: assert property ((configured_o && $stable(pins)) [*5] |-> $stable(cell_q_o))
		else $error("cell output moved with quiet pins");
	cover property ($rose(configured_o));
	cover property (configured_o && !(&cell_q_o));
	cover property (configured_o && $changed(cell_q_o));
endmodule : fabric_clock_reset_distribution_props

bind fabric_clock_reset_distribution fabric_clock_reset_distribution_props #(
	.NUM_COLS(NUM_COLS), .SECTORS_PER_COL(SECTORS_PER_COL), .NUM_USER_IO(NUM_USER_IO)
) fabric_clock_reset_distribution_props_i (
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .global_clock_lines_i(global_clock_lines_i),
	.fast_clk_west_a_i(fast_clk_west_a_i), .fast_clk_west_b_i(fast_clk_west_b_i),
	.fast_clk_east_a_i(fast_clk_east_a_i), .fast_clk_east_b_i(fast_clk_east_b_i),
	.user_io_i(user_io_i), .express_clk_i(express_clk_i), .express_sr_i(express_sr_i),
	.config_done_i(config_done_i), .cell_q_o(cell_q_o), .configured_o(configured_o));

// ---- testbench/test_fabric_clock_reset_distribution.sv ----
// bench: random and corner tests of the fabric clock and set/reset block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_fabric_clock_reset_distribution;
	import fabric_clk_pkg::*;
	// ****************************************
	// stimulus and model state
	// ****************************************
	localparam int NS = 8;
	localparam int NQ = 32;
	logic			clk_sys_i = 1'h0;
	logic			resetn_i = 1'h0;
	logic [7:0]		glb = 8'h00;
	logic [3:0]		fst = 4'h0;
	logic [7:0]		uio = 8'hFF;
	logic [NS-1:0]		xclk = 8'h00;
	logic [NS-1:0]		xsr = 8'hFF;
	logic			done = 1'h0;
	logic [15:0]		csel = 16'h0000;
	sector_cfg_type [NS-1:0]	scfg = {NS{SECTOR_CFG_RESET}};
	cell_cfg_type [NQ-1:0]	ccfg = {NQ{CELL_CFG_RESET}};
	logic [2:0]		gsel = 3'h0;
	logic [NQ-1:0]		d = 32'h00000000;
	logic [NQ-1:0]		q;
	logic			cfgd;
	sector_cfg_type [NS-1:0]	ms;
	cell_cfg_type [NQ-1:0]	mc;
	logic [15:0]		msel;
	logic [2:0]		mg;
	logic [NQ-1:0]		mq;
	logic [NS-1:0]		mdel;
	logic [31:0]		seed = 32'h0000002F;
	int			fail_count = 0;
	int			total_checks = 0;

	fabric_clock_reset_distribution #(.NUM_COLS(4), .SECTORS_PER_COL(2), .NUM_USER_IO(8))
	fabric_clock_reset_distribution_i (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .global_clock_lines_i(glb),
		.fast_clk_west_a_i(fst[0]), .fast_clk_west_b_i(fst[1]),
		.fast_clk_east_a_i(fst[2]), .fast_clk_east_b_i(fst[3]),
		.user_io_i(uio), .express_clk_i(xclk), .express_sr_i(xsr),
		.config_done_i(done), .col_clk_sel_i(csel), .sector_cfg_i(scfg),
		.cell_cfg_i(ccfg), .gsr_pin_sel_i(gsel), .cell_d_i(d),
		.cell_q_o(q), .configured_o(cfgd));

	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] lfsr(logic [31:0] v);
		for (int i = 0; i < 32; i++) begin
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		end
		return v;
	endfunction : lfsr

	// delivered sector clock level from the pins and the frozen settings
	function automatic logic del_lvl(int s);
		logic [3:0] sel;
		logic lvl;
		int c;
		c = s / 2;
		sel = msel[c*4 +: 4];
		lvl = 1'h0;
		if (sel < 4'h8) lvl = glb[sel[2:0]];
		else if (c == 0 && sel == SEL_FAST_A) lvl = fst[0];
		else if (c == 0 && sel == SEL_FAST_B) lvl = fst[1];
		else if (c == 3 && sel == SEL_FAST_A) lvl = fst[2];
		else if (c == 3 && sel == SEL_FAST_B) lvl = fst[3];
		if (ms[s].clk_from_express) lvl = xclk[s];
		if (ms[s].clk_mode == CLK_OFF) return 1'h0;
		return (ms[s].clk_mode == CLK_INV) ? ~lvl : lvl;
	endfunction : del_lvl

	task automatic settle(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : settle

	task automatic configure();
		@(posedge clk_sys_i);
		seed = lfsr(seed);
		msel = seed[15:0];
		mg = seed[18:16];
		for (int s = 0; s < NS; s++) begin
			seed = lfsr(seed);
			ms[s].clk_from_express = seed[0];
			if (seed[2] & seed[5]) begin
				ms[s].clk_mode = CLK_OFF;
			end else if (seed[1]) begin
				ms[s].clk_mode = CLK_TRUE;
			end else begin
				ms[s].clk_mode = CLK_INV;
			end
			ms[s].sr_from_express = seed[3];
			ms[s].sr_invert = seed[3] & seed[4];
			xsr[s] <= ~(seed[3] & seed[4]);
		end
		for (int i = 0; i < NQ; i++) begin
			seed = lfsr(seed);
			mc[i] = seed[2:0];
			// data equals the power-up state, so the start edge is harmless
			d[i] <= seed[0];
		end
		csel <= msel;
		scfg <= ms;
		ccfg <= mc;
		gsel <= mg;
		uio <= 8'hFF;
		repeat (3) @(posedge clk_sys_i);
		done <= 1'h1;
		settle(4);
		mq = d;
		`CHK("power-up state", mq, q)
		`CHK("configured", 1'h1, cfgd)
		@(posedge clk_sys_i);
		for (int s = 0; s < NS; s++) begin
			mdel[s] = del_lvl(s);
			scfg[s].clk_mode <= CLK_OFF;
			scfg[s].sr_invert <= ~ms[s].sr_invert;
		end
		csel <= ~msel;
		ccfg <= ~mc;
		gsel <= ~mg;
	endtask : configure

	task automatic clock_round(int n);
		logic nd;
		repeat (n) begin
			@(posedge clk_sys_i);
			seed = lfsr(seed);
			glb <= seed[7:0];
			fst <= seed[11:8];
			xclk <= seed[19:12];
			d <= lfsr(seed);
			settle(6);
			for (int s = 0; s < NS; s++) begin
				nd = del_lvl(s);
				for (int k = 0; k < 4; k++) begin
					if (!done) mq[s*4+k] = 1'h1;
					else if (nd != mdel[s] && nd != mc[s*4+k].falling_edge) mq[s*4+k] = d[s*4+k];
				end
				mdel[s] = nd;
			end
			`CHK("clocked cells", mq, q)
		end
	endtask : clock_round

	task automatic sr_round(int n);
		logic [NS-1:0] act;
		logic [7:0] u;
		repeat (n) begin
			@(posedge clk_sys_i);
			seed = lfsr(seed);
			act = seed[NS-1:0];
			for (int s = 0; s < NS; s++) begin
				if (!ms[s].sr_from_express) act[s] = seed[8];
				xsr[s] <= ms[s].sr_invert ~^ act[s];
			end
			u = seed[23:16];
			u[mg] = ~seed[8];
			uio <= u;
			// two edges only: the override must show before any cell clock edge
			settle(2);
			for (int i = 0; i < NQ; i++) begin
				if (act[i/4]) mq[i] = mc[i].sr_sets;
			end
			`CHK("set/reset cells", mq, q)
			@(posedge clk_sys_i);
			for (int s = 0; s < NS; s++) begin
				xsr[s] <= ~ms[s].sr_invert;
			end
			u = seed[31:24];
			u[mg] = 1'h1;
			uio <= u;
			settle(4);
			`CHK("released cells", mq, q)
		end
	endtask : sr_round

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// test sequence and watchdog
	// ****************************************
	initial begin
		repeat (4) @(posedge clk_sys_i);
		resetn_i <= 1'h1;
		settle(1);
		mq = {NQ{1'h1}};
		`CHK("cells after reset", mq, q)
		`CHK("configured after reset", 1'h0, cfgd)
		clock_round(4);
		$display("test unconfigured clocks ended");
		for (int p = 0; p < 4; p++) begin
			configure();
			clock_round(12);
			sr_round(3);
			clock_round(4);
			@(posedge clk_sys_i);
			done <= 1'h0;
			settle(3);
			mq = {NQ{1'h1}};
			`CHK("cells unconfigured", mq, q)
			$display("test pass %0d ended", p);
		end
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge clk_sys_i);
		fail_count++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule : test_fabric_clock_reset_distribution
